//--- bench/i2c_bus_partner.sv
`timescale 1ns/100ps
module i2c_bus_partner (
  // Commands from the bench.
  input wire logic hold_clock,
  input wire logic jam_data,
  // Open-drain pulls onto the shared lines.
  output logic scl_low,
  output logic sda_low
);
  // A slow node stretching the clock; the lines float high once released.
  assign scl_low = hold_clock;
  // A rival master that wins arbitration by holding data low.
  assign sda_low = jam_data;
endmodule

//--- bench/i2c_master_seq_monitor.sv
`timescale 1ns/100ps
module i2c_master_seq_monitor (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Register bus.
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // Bus lines.
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // Interrupt.
  input wire logic irq
);
  // ************************************************************
  // Properties
  // ************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // A request in its first cycle, and the edge that takes it.
  sequence req_waiting;
    (read || write) && waitrequest;
  endsequence
  sequence req_taken;
    (read || write) && !waitrequest;
  endsequence
  // A held request is answered in its second cycle.
  AST_WAIT_ANSWER: assert property (req_waiting ##1 (read || write) |-> req_taken)
    else $error("request not answered in its second cycle");
  // Read data moves only after a read, so software never sees it drift.
  AST_RD_STABLE: assert property (!$past(read) |-> $stable(readdata))
    else $error("read data changed without a read");
  // A clock held low by another node freezes the master's clock phase.
  AST_STRETCH_HOLD: assert property (!scl_oe && !scl_in |=> !scl_oe)
    else $error("clock pulled low while stretched");
  // The high phase is counted only from a sampled high clock.
  AST_SCL_HIGH_FIRST: assert property ($rose(scl_oe) |-> $past(scl_in))
    else $error("clock pulled low without a high phase");
  // Start: data falls only while the clock is high.
  AST_START_SCL_HIGH: assert property ($rose(sda_oe) && !scl_oe |-> scl_in)
    else $error("start condition without a high clock");
  // Stop: data rises only while the released clock is high.
  AST_STOP_SCL_HIGH: assert property ($fell(sda_oe) && !scl_oe && !$past(scl_oe) |-> scl_in)
    else $error("stop condition without a high clock");
  // Interrupts are sticky: only a taken write can lower the line.
  AST_IRQ_STICKY: assert property ($fell(irq) |-> $past(write && !waitrequest))
    else $error("interrupt dropped without a write");
  // Open drain: the pins only ever pull low, a high level is a release.
  AST_DRIVE_LOW: assert property (!scl_out && !sda_out)
    else $error("bus line driven high");
endmodule

bind i2c_master_seq i2c_master_seq_monitor mon (.clk, .reset, .address, .read, .write,
  .writedata, .readdata, .waitrequest, .scl_in, .scl_out, .scl_oe, .sda_in, .sda_out,
  .sda_oe, .irq);

//--- bench/test_i2c_master_sequencing_arbitration.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("FAIL %s exp %h got %h", n, e, g); end end
module test_i2c_master_sequencing_arbitration;
  // ************************************************************
  // Bench signals
  // ************************************************************
  logic clk, reset, read, write, waitrequest, irq, hold_clock, jam_data, scl_low, sda_low;
  logic scl_in, scl_out, scl_oe, sda_in, sda_out, sda_oe;
  logic [3:0] address;
  logic [31:0] writedata, readdata, seed;
  int n_mismatch, n_checks;
  typedef struct {string name; logic [31:0] mask; logic [31:0] value;} note_t;
  note_t notes[$];

  i2c_master_seq dut (.clk, .reset, .address, .read, .write, .writedata, .readdata,
    .waitrequest, .scl_in, .scl_out, .scl_oe, .sda_in, .sda_out, .sda_oe, .irq);
  i2c_bus_partner peer (.hold_clock, .jam_data, .scl_low, .sda_low);

  // Wired-AND lines with pull-ups: whoever pulls low wins.
  assign scl_in = !(scl_oe || scl_low);
  assign sda_in = !(sda_oe || sda_low);

  // Clock generator.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic results();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Holds the request until waitrequest is seen low, then lets it go after that edge.
  task automatic bus(input logic wr_en, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    read <= !wr_en;
    write <= wr_en;
    address <= a;
    writedata <= d;
    do begin
      @(negedge clk);
      k++;
    end while (waitrequest !== 1'b0 && k < 20);
    if (waitrequest !== 1'b0) begin
      n_mismatch++;
      results();
    end
    @(posedge clk);
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e,
                    input string nm);
    notes.push_back('{nm, m, e});
    bus(1'b0, a, 32'h0);
  endtask

  task automatic wait_irq();
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 20000) begin
      @(negedge clk);
      k++;
    end
    if (irq !== 1'b1) begin
      n_mismatch++;
      results();
    end
  endtask

  // One event lost to a rival holding data low; the master must give up and stay idle.
  task automatic collide(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    jam_data <= 1'b1;
    bus(1'b1, a, d);
    wait_irq();
    rd(4'h1, 32'h24401, 32'h20400, "collision");
    rd(4'h0, 32'h1F, 32'h0, "aborted");
    repeat (50) @(negedge clk);
    `CHK("released", 2'b00, {scl_oe, sda_oe})
    rd(4'h0, 32'h1F, 32'h0, "no retry");
    jam_data <= 1'b0;
    bus(1'b1, 4'h1, 32'h30480);
    @(negedge clk);
    `CHK("irq clear", 1'b0, irq)
  endtask

  // One event that must finish cleanly: the request drops and the event interrupts.
  task automatic run_event(input logic [31:0] d, input string nm);
    bus(1'b1, 4'h0, d);
    wait_irq();
    rd(4'h1, 32'h400, 32'h0, nm);
    rd(4'h0, 32'h1F, 32'h0, nm);
    bus(1'b1, 4'h1, 32'h30480);
  endtask

  // Each read result is compared with the oldest note in the cycle the bus takes it.
  always @(negedge clk) begin
    note_t t;
    if (read === 1'b1 && waitrequest === 1'b0) begin
      t = notes.pop_front();
      `CHK(t.name, t.value, readdata & t.mask)
    end
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    reset = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 4'h0;
    writedata = 32'h0;
    hold_clock = 1'b0;
    jam_data = 1'b0;
    seed = 32'h02ABD1BC;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rd(4'h2, 32'hFFF, 32'h0FF, "baud reset");
    rd(4'h0, 32'h1F, 32'h0, "ctrl idle");
    rd(4'h1, 32'h4000, 32'h0, "tx idle");
    rd(4'h9, 32'hFFFFFFFF, 32'h0, "unmapped");
    // A short random reload keeps every bus phase brief.
    seed = xs(seed);
    bus(1'b1, 4'h2, {30'h0, seed[1:0]} + 32'h2);
    rd(4'h2, 32'hFFF, {30'h0, seed[1:0]} + 32'h2, "baud");
    bus(1'b1, 4'h5, 32'h3);
    // A stop written while the start runs must be dropped, not queued.
    bus(1'b1, 4'h0, 32'h1);
    bus(1'b1, 4'h0, 32'h4);
    rd(4'h0, 32'h1F, 32'h1, "ctrl start");
    wait_irq();
    rd(4'h0, 32'h1F, 32'h0, "ctrl done");
    // Masking hides the interrupt while the status flag stays set.
    bus(1'b1, 4'h5, 32'h2);
    @(negedge clk);
    `CHK("irq masked", 1'b0, irq)
    rd(4'h1, 32'h10000, 32'h10000, "event flag");
    bus(1'b1, 4'h5, 32'h3);
    @(negedge clk);
    `CHK("irq unmasked", 1'b1, irq)
    bus(1'b1, 4'h1, 32'h30480);
    @(negedge clk);
    `CHK("irq cleared", 1'b0, irq)
    // Random byte, stretched mid-flight by the far side; nobody acknowledges.
    seed = xs(seed);
    bus(1'b1, 4'h3, {24'h0, seed[7:0]});
    rd(4'h1, 32'h4001, 32'h4001, "tx busy");
    rd(4'h0, 32'h1F, 32'h0, "ctrl tx");
    bus(1'b1, 4'h3, 32'h55);
    rd(4'h1, 32'h80, 32'h80, "write coll");
    hold_clock <= 1'b1;
    repeat (40) @(posedge clk);
    hold_clock <= 1'b0;
    wait_irq();
    rd(4'h1, 32'h8481, 32'h8080, "nack");
    bus(1'b1, 4'h1, 32'h30480);
    // Lost stop, then a fresh start and a lost byte; a lost start closes the run.
    collide(4'h0, 32'h4);
    bus(1'b1, 4'h0, 32'h1);
    wait_irq();
    bus(1'b1, 4'h1, 32'h30480);
    seed = xs(seed);
    collide(4'h3, {24'h0, 1'b1, seed[6:0]});
    // A clean message through every other event kind; nobody drives data, so 8'hFF comes in.
    run_event(32'h1, "start");
    run_event(32'h2, "restart");
    run_event(32'h8, "receive");
    rd(4'h4, 32'hFF, 32'hFF, "rx byte");
    rd(4'h1, 32'h2, 32'h0, "rx read");
    run_event(32'h30, "nack");
    run_event(32'h4, "stop");
    rd(4'h1, 32'h18, 32'h10, "stop seen");
    collide(4'h0, 32'h1);
    results();
  end
endmodule

//--- logic/i2c_baud_counter.sv
`timescale 1ns/100ps
module i2c_baud_counter (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Control.
  input wire logic run,
  input wire logic scl_released,
  input wire logic scl_in,
  input wire logic [11:0] reload,
  // Timeout pulse.
  output logic tick
);

  typedef struct packed {
    logic [11:0] count;
    logic waiting;
  } baud_state_t;

  baud_state_t s_r;
  baud_state_t s_nxt;

  // Counting stalls while the clock line is released yet still low, so a slow
  // peer stretches our high time instead of shortening it.
  always_comb begin
    s_nxt = s_r;
    tick = 1'b0;
    if (!run) begin
      s_nxt.count = reload;
      s_nxt.waiting = 1'b0;
    end else if (scl_released && !scl_in) begin
      s_nxt.waiting = 1'b1;
    end else if (s_r.waiting) begin
      s_nxt.waiting = 1'b0;
      s_nxt.count = reload;
    end else if (s_r.count == 12'h000) begin
      tick = 1'b1;
      s_nxt.count = reload;
    end else begin
      s_nxt.count = s_r.count - 12'h001;
    end
  end

  // State register.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

//--- logic/i2c_bus_arbiter.sv
`timescale 1ns/100ps
module i2c_bus_arbiter (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Bus sense.
  input wire logic check,
  input wire logic sda_drive_low,
  input wire logic sda_in,
  input wire logic scl_in,
  // Results.
  output logic collision,
  output logic start_seen,
  output logic stop_seen
);

  typedef struct packed {
    logic sda_d;
    logic scl_d;
    logic start_seen;
    logic stop_seen;
  } arb_state_t;

  arb_state_t s_r;
  arb_state_t s_nxt;

  // A low on the data line while we let it float means another master won.
  assign collision = check && !sda_drive_low && !sda_in;
  assign start_seen = s_r.start_seen;
  assign stop_seen = s_r.stop_seen;

  // Start and stop detection for the idle-bus check software performs.
  always_comb begin
    s_nxt = s_r;
    s_nxt.sda_d = sda_in;
    s_nxt.scl_d = scl_in;
    if (scl_in && s_r.scl_d && s_r.sda_d && !sda_in) begin
      s_nxt.start_seen = 1'b1;
      s_nxt.stop_seen = 1'b0;
    end else if (scl_in && s_r.scl_d && !s_r.sda_d && sda_in) begin
      s_nxt.start_seen = 1'b0;
      s_nxt.stop_seen = 1'b1;
    end
  end

  // State register; lines idle high.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_r <= 4'hC;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

//--- logic/i2c_master_pkg.sv
package i2c_master_pkg;

  // ************************************************************
  // Register map (word addresses, one 32-bit word each)
  // ************************************************************
  localparam logic [3:0] ctrl_addr = 4'h0;
  localparam logic [3:0] status_addr = 4'h1;
  localparam logic [3:0] baud_addr = 4'h2;
  localparam logic [3:0] txbuf_addr = 4'h3;
  localparam logic [3:0] rxbuf_addr = 4'h4;
  localparam logic [3:0] irq_mask_addr = 4'h5;

  // ************************************************************
  // Control register fields
  // ************************************************************
  localparam int start_bit = 0;
  localparam int restart_bit = 1;
  localparam int stop_bit = 2;
  localparam int receive_bit = 3;
  localparam int ack_bit = 4;
  localparam int ack_value_bit = 5;
  localparam int event_bits = 5;

  // ************************************************************
  // Status register fields
  // ************************************************************
  localparam int tx_full_bit = 0;
  localparam int rx_full_bit = 1;
  localparam int start_seen_bit = 3;
  localparam int stop_seen_bit = 4;
  localparam int write_coll_bit = 7;
  localparam int collision_bit = 10;
  localparam int tx_active_bit = 14;
  localparam int ack_status_bit = 15;
  localparam int event_irq_bit = 16;
  localparam int coll_irq_bit = 17;

  // ************************************************************
  // Widths and reset values
  // ************************************************************
  localparam int baud_width = 12;
  localparam logic [11:0] baud_reset = 12'h0FF;
  localparam logic [3:0] bits_per_byte = 4'h8;

  // Master event sequencer states.
  typedef enum logic [3:0] {
    st_idle, st_start, st_restart, st_stop, st_tx, st_rx, st_ack, st_ackbit
  } master_state_t;

endpackage

//--- logic/i2c_master_seq.sv
// The Avalon-MM slave port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
// What this block does
// - Five event requests in control bits 0-4.
// - Status bit 14 shows byte transmit active.
// - Baud counter holds while released clock held low.
// - Clock seen high reloads counter from bits 11:0.
// - Arbitration and synchronisation always on.
// - Released-high data sampled low means collision.
// - Collision sets status bit 10, interrupts.
// - Lost arbitration returns master to idle.
// - Check start, restart, bits, ack, stop.
// - Byte collision halts shift, clears full, releases.
// - Sequence collision aborts, clears request, releases.
// - Event bit writes ignored while event active.
// - Completion clears request, raises event interrupt.
module i2c_master_seq (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Avalon-MM slave.
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Bus lines, open drain.
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Interrupt.
  output logic irq
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    i2c_master_pkg::master_state_t st;
    logic [4:0] req;
    logic ack_value;
    logic [11:0] baud;
    logic [7:0] shreg;
    logic [7:0] rxbuf;
    logic [3:0] bitcnt;
    logic [1:0] phase;
    logic scl_low;
    logic sda_low;
    logic tx_full;
    logic rx_full;
    logic wcol;
    logic coll;
    logic ack_stat;
    logic ev_irq;
    logic [1:0] mask;
    logic ack;
    logic [31:0] rdata;
  } seq_state_t;

  seq_state_t s_r;
  seq_state_t s_nxt;
  logic tick;
  logic collide;
  logic start_seen;
  logic stop_seen;
  logic check;
  logic [31:0] status;

  // Read-back word for the status register.
  function automatic logic [31:0] status_word(input seq_state_t s, input logic sa,
                                               input logic so);
    logic [31:0] w;
    w = '0;
    w[i2c_master_pkg::tx_full_bit] = s.tx_full;
    w[i2c_master_pkg::rx_full_bit] = s.rx_full;
    w[i2c_master_pkg::start_seen_bit] = sa;
    w[i2c_master_pkg::stop_seen_bit] = so;
    w[i2c_master_pkg::write_coll_bit] = s.wcol;
    w[i2c_master_pkg::collision_bit] = s.coll;
    w[i2c_master_pkg::tx_active_bit] = (s.st == i2c_master_pkg::st_tx);
    w[i2c_master_pkg::ack_status_bit] = s.ack_stat;
    w[i2c_master_pkg::event_irq_bit] = s.ev_irq;
    w[i2c_master_pkg::coll_irq_bit] = s.coll;
    return w;
  endfunction

  // ************************************************************
  // Submodules
  // ************************************************************
  i2c_baud_counter baud_i (
    .clk(clk),
    .reset(reset),
    .run(s_r.st != i2c_master_pkg::st_idle),
    .scl_released(!s_r.scl_low),
    .scl_in(scl_in),
    .reload(s_r.baud),
    .tick(tick)
  );

  // Data is checked while a sequence owning the line lets it float and the clock is high.
  assign check = (s_r.st != i2c_master_pkg::st_idle) && (s_r.st != i2c_master_pkg::st_rx)
                 && (s_r.st != i2c_master_pkg::st_ackbit) && !s_r.sda_low && scl_in;

  i2c_bus_arbiter arb_i (
    .clk(clk),
    .reset(reset),
    .check(check),
    .sda_drive_low(s_r.sda_low),
    .sda_in(sda_in),
    .scl_in(scl_in),
    .collision(collide),
    .start_seen(start_seen),
    .stop_seen(stop_seen)
  );

  // ************************************************************
  // Outputs
  // ************************************************************
  assign status = status_word(s_r, start_seen, stop_seen);
  assign scl_out = 1'b0;
  assign scl_oe = s_r.scl_low;
  assign sda_out = 1'b0;
  assign sda_oe = s_r.sda_low;
  assign readdata = s_r.rdata;
  assign waitrequest = (read || write) && !s_r.ack;
  assign irq = |({s_r.coll, s_r.ev_irq} & s_r.mask);

  // Sequencer, bus slave and flags. Each bit, restart and stop walks four baud phases; a start takes three.
  always_comb begin
    logic done;
    logic wr;
    logic [31:0] wd;
    done = 1'b0;
    wr = write && s_r.ack; // A write lands only on the edge that answers it.
    wd = writedata;
    s_nxt = s_r;
    s_nxt.ack = (read || write) && !s_r.ack;
    if (tick) begin
      s_nxt.phase = s_r.phase + 2'h1;
      unique case (s_r.st)
        i2c_master_pkg::st_start: begin
          unique case (s_r.phase)
            2'h0: s_nxt.sda_low = 1'b1;
            2'h1: s_nxt.scl_low = 1'b1;
            default: done = 1'b1;
          endcase
        end
        i2c_master_pkg::st_restart: begin
          unique case (s_r.phase)
            2'h0: s_nxt.scl_low = 1'b1;
            2'h1: begin
              s_nxt.sda_low = 1'b0;
              s_nxt.scl_low = 1'b0;
            end
            2'h2: s_nxt.sda_low = 1'b1;
            default: begin
              s_nxt.scl_low = 1'b1;
              done = 1'b1;
            end
          endcase
        end
        i2c_master_pkg::st_stop: begin
          unique case (s_r.phase)
            2'h0: begin
              s_nxt.scl_low = 1'b1;
              s_nxt.sda_low = 1'b1;
            end
            2'h1: s_nxt.scl_low = 1'b0;
            2'h2: s_nxt.sda_low = 1'b0;
            default: done = 1'b1;
          endcase
        end
        default: begin
          // Bit engine shared by transmit, receive and acknowledge.
          unique case (s_r.phase)
            2'h0: begin
              s_nxt.scl_low = 1'b1;
              if (s_r.st == i2c_master_pkg::st_tx) begin
                s_nxt.sda_low = !s_r.shreg[7];
              end else if (s_r.st == i2c_master_pkg::st_ack) begin
                s_nxt.sda_low = !s_r.ack_value;
              end else begin
                s_nxt.sda_low = 1'b0;
              end
            end
            2'h1: s_nxt.scl_low = 1'b0;
            2'h2: begin
              if (s_r.st == i2c_master_pkg::st_ackbit) begin
                s_nxt.ack_stat = sda_in;
              end else begin
                s_nxt.shreg = {s_r.shreg[6:0], sda_in};
              end
            end
            default: begin
              s_nxt.scl_low = 1'b1;
              s_nxt.bitcnt = s_r.bitcnt + 4'h1;
              if (s_r.st == i2c_master_pkg::st_ack ||
                  s_r.st == i2c_master_pkg::st_ackbit) begin
                s_nxt.sda_low = 1'b0;
                done = 1'b1;
              end else if (s_r.bitcnt == i2c_master_pkg::bits_per_byte - 4'h1) begin
                if (s_r.st == i2c_master_pkg::st_tx) begin
                  s_nxt.tx_full = 1'b0;
                  s_nxt.sda_low = 1'b0;
                  s_nxt.st = i2c_master_pkg::st_ackbit;
                end else begin
                  s_nxt.rx_full = 1'b1;
                  s_nxt.rxbuf = s_r.shreg;
                  done = 1'b1;
                end
              end
            end
          endcase
        end
      endcase
    end
    // Completion drops the request and flags the event.
    if (done) begin
      s_nxt.st = i2c_master_pkg::st_idle;
      s_nxt.req = '0;
      s_nxt.ev_irq = 1'b1;
      s_nxt.sda_low = (s_r.st == i2c_master_pkg::st_start) ||
                      (s_r.st == i2c_master_pkg::st_restart);
      s_nxt.phase = '0;
    end
    // Collision: abort whatever runs and let go of both lines.
    if (collide) begin
      s_nxt.st = i2c_master_pkg::st_idle;
      s_nxt.req = '0;
      s_nxt.tx_full = 1'b0;
      s_nxt.scl_low = 1'b0;
      s_nxt.sda_low = 1'b0;
      s_nxt.phase = '0;
      s_nxt.coll = 1'b1;
    end
    // Register writes; hardware sets beat software clears.
    if (wr) begin
      unique case (address)
        i2c_master_pkg::ctrl_addr: begin
          s_nxt.ack_value = wd[i2c_master_pkg::ack_value_bit];
          if (s_r.st == i2c_master_pkg::st_idle && !collide &&
              |wd[i2c_master_pkg::event_bits-1:0]) begin
            s_nxt.req = wd[i2c_master_pkg::event_bits-1:0];
            s_nxt.phase = '0;
            s_nxt.bitcnt = '0;
            if (wd[i2c_master_pkg::start_bit]) begin
              s_nxt.st = i2c_master_pkg::st_start;
            end else if (wd[i2c_master_pkg::restart_bit]) begin
              s_nxt.st = i2c_master_pkg::st_restart;
            end else if (wd[i2c_master_pkg::stop_bit]) begin
              s_nxt.st = i2c_master_pkg::st_stop;
            end else if (wd[i2c_master_pkg::receive_bit]) begin
              s_nxt.st = i2c_master_pkg::st_rx;
            end else begin
              s_nxt.st = i2c_master_pkg::st_ack;
            end
          end
        end
        i2c_master_pkg::status_addr: begin
          if (wd[i2c_master_pkg::write_coll_bit]) s_nxt.wcol = 1'b0;
          if (wd[i2c_master_pkg::event_irq_bit] && !done) s_nxt.ev_irq = 1'b0;
          if ((wd[i2c_master_pkg::collision_bit] || wd[i2c_master_pkg::coll_irq_bit])
              && !collide) s_nxt.coll = 1'b0;
        end
        i2c_master_pkg::baud_addr: s_nxt.baud = wd[i2c_master_pkg::baud_width-1:0];
        i2c_master_pkg::txbuf_addr: begin
          if (s_r.st == i2c_master_pkg::st_idle && !collide) begin
            s_nxt.shreg = wd[7:0];
            s_nxt.tx_full = 1'b1;
            s_nxt.st = i2c_master_pkg::st_tx;
            s_nxt.phase = '0;
            s_nxt.bitcnt = '0;
          end else begin
            s_nxt.wcol = 1'b1;
          end
        end
        i2c_master_pkg::irq_mask_addr: s_nxt.mask = wd[1:0];
        default: ;
      endcase
    end
    // Read data is latched in the request's first cycle, while waitrequest is still high.
    if (read && !s_r.ack) begin
      unique case (address)
        i2c_master_pkg::ctrl_addr: s_nxt.rdata = {26'h0, s_r.ack_value, s_r.req};
        i2c_master_pkg::status_addr: s_nxt.rdata = status;
        i2c_master_pkg::baud_addr: s_nxt.rdata = {20'h0, s_r.baud};
        i2c_master_pkg::rxbuf_addr: begin
          s_nxt.rdata = {24'h0, s_r.rxbuf};
          // A byte landing in the same cycle keeps its flag set.
          if (!(done && s_r.st == i2c_master_pkg::st_rx)) s_nxt.rx_full = 1'b0;
        end
        i2c_master_pkg::irq_mask_addr: s_nxt.rdata = {30'h0, s_r.mask};
        default: s_nxt.rdata = '0;
      endcase
    end
  end

  // State register.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_r <= '{st: i2c_master_pkg::st_idle, baud: i2c_master_pkg::baud_reset,
               default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule
